// [tcm_pkg.sv]
// package: constants for the tandem connection monitor
package tcm_pkg;
  localparam logic [3:0] ALARM_CODE = 4'he;
  localparam logic [7:0] UNEQ_BYTE = 8'h00;
  localparam logic [2:0] PERSIST_FRAMES = 3'h5;
  localparam int CLK_MHZ = 50;
  localparam int FILL_TIME_US = 250;
  localparam int FILL_MAX_CYCLES = FILL_TIME_US * CLK_MHZ;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] FA1_VALUE = 8'hf6;
  localparam logic [7:0] FA2_VALUE = 8'h28;
  localparam logic [3:0] ERR_W = 4'h4;
  localparam int CNT_W = 24;
  localparam logic [15:0] FRAME_BYTES = 16'h0900;
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 8;
endpackage

// [tcm_fifo.sv]
// fifo: parameterised synchronous buffer with valid and ready
`timescale 1ns/100ps
module tcm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_reg[rd_reg];
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [tandem_connection_monitor.sv]
// tandem connection sink, adaptation source and sink
`timescale 1ns/100ps
// How it works
// - alarm code 1110 five frames sets alarm
// - five frames of other codes clear it
// - only code 1110 means alarm true
// - fill request from unequipped, mismatch, loss
// - trail fail and remote defect actions
// - outgoing defect action includes upstream alarm
// - outgoing fail action toward adaptation sink
// - degrade, remote error, outgoing error actions
// - all-ones insertion follows fill request promptly
// - unequipped fault; loss fault masked by unequipped
// - mismatch fault masked by unequipped, loss
// - degrade fault masked by mismatch, loss
// - server fault needs its enable
// - far defect fault gated and masked
// - far outgoing fault gated and masked
// - upstream alarm fault gated and masked
// - four report enables, default disabled
// - near and outgoing near defect seconds
// - far seconds flags and block error sums
// - holdover frames: alignment bytes, else ones
// - holdover timing from reference clock
// - adaptation sink restores fail, requests fill
// - unequipped detected over five frames
// - loss follows multiframe alignment state
module tandem_connection_monitor
  import tcm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_frame_start,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_data,
  input wire logic [7:0] i_tandem_overhead_byte,
  input wire logic i_server_fail_input,
  input wire logic i_multiframe_lost_state,
  input wire logic i_trace_mismatch_defect,
  input wire logic i_degrade_defect,
  input wire logic i_far_defect_indication,
  input wire logic i_far_outgoing_defect,
  input wire logic i_equipment_defect,
  input wire logic [3:0] i_near_block_error,
  input wire logic i_outgoing_near_block_error,
  input wire logic [3:0] i_far_block_error,
  input wire logic i_outgoing_far_block_error,
  input wire logic i_monitored_state,
  input wire logic i_server_fail_report_enable,
  input wire logic i_far_defect_report_enable,
  input wire logic i_far_outgoing_report_enable,
  input wire logic i_upstream_alarm_report_enable,
  input wire logic i_config_load,
  input wire logic i_one_second,
  input wire logic i_timing_reference_clock,
  input wire logic i_adapted_outgoing_fail,
  input wire logic [7:0] i_adapted_data,
  input wire logic i_out_ready,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [7:0] o_out_data,
  output logic o_out_frame_start,
  output logic o_upstream_alarm_defect,
  output logic o_unequipped_defect,
  output logic o_tandem_loss_defect,
  output logic o_alarm_fill_request,
  output logic o_trail_fail_action,
  output logic o_trail_degrade_action,
  output logic o_remote_defect_action,
  output logic o_remote_error_action,
  output logic o_outgoing_defect_action,
  output logic o_outgoing_error_action,
  output logic o_outgoing_fail_action,
  output logic o_fault_unequipped,
  output logic o_fault_loss,
  output logic o_fault_mismatch,
  output logic o_fault_degrade,
  output logic o_fault_server,
  output logic o_fault_far_defect,
  output logic o_fault_far_outgoing,
  output logic o_fault_upstream_alarm,
  output logic o_near_defect_seconds,
  output logic o_far_defect_seconds,
  output logic o_outgoing_near_seconds,
  output logic o_outgoing_far_seconds,
  output logic [CNT_W-1:0] o_near_block_count,
  output logic [CNT_W-1:0] o_far_block_count,
  output logic [CNT_W-1:0] o_outgoing_near_count,
  output logic [CNT_W-1:0] o_outgoing_far_count,
  output logic [7:0] o_holdover_data,
  output logic o_holdover_frame_start,
  output logic o_adapted_fail_output,
  output logic [7:0] o_sink_data,
  output logic o_sink_server_fail,
  output logic o_sink_fill_request
);
  // ------------------------------------------------------------
  // persistence filter
  // ------------------------------------------------------------
  // shared five-frame filter: steps toward the opposite state
  function automatic logic [2:0] persist_next(input logic state, input logic hit,
                                               input logic [2:0] cnt);
    if (hit == state) begin
      persist_next = 3'h0;
    end else begin
      persist_next = cnt + 3'h1;
    end
  endfunction

  logic alarm_code_seen;
  logic uneq_seen;
  logic upstream_alarm_reg;
  logic unequipped_reg;
  logic [2:0] alarm_cnt_reg;
  logic [2:0] uneq_cnt_reg;
  logic [2:0] alarm_cnt_next;
  logic [2:0] uneq_cnt_next;

  assign alarm_code_seen = (i_tandem_overhead_byte[7:4] == ALARM_CODE);
  assign uneq_seen = (i_tandem_overhead_byte == UNEQ_BYTE);
  assign alarm_cnt_next = persist_next(upstream_alarm_reg, alarm_code_seen, alarm_cnt_reg);
  assign uneq_cnt_next = persist_next(unequipped_reg, uneq_seen, uneq_cnt_reg);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      upstream_alarm_reg <= 1'b0;
      alarm_cnt_reg <= 3'h0;
    end else if (i_frame_start) begin
      if (alarm_cnt_next == PERSIST_FRAMES) begin
        upstream_alarm_reg <= alarm_code_seen;
        alarm_cnt_reg <= 3'h0;
      end else begin
        alarm_cnt_reg <= alarm_cnt_next;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      unequipped_reg <= 1'b0;
      uneq_cnt_reg <= 3'h0;
    end else if (i_frame_start) begin
      if (uneq_cnt_next == PERSIST_FRAMES) begin
        unequipped_reg <= uneq_seen;
        uneq_cnt_reg <= 3'h0;
      end else begin
        uneq_cnt_reg <= uneq_cnt_next;
      end
    end
  end

  // ------------------------------------------------------------
  // management settings and loss state
  // ------------------------------------------------------------
  logic loss_reg;
  logic ssf_en_reg;
  logic rdi_en_reg;
  logic odi_en_reg;
  logic ais_en_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      loss_reg <= 1'b0;
    end else begin
      loss_reg <= i_multiframe_lost_state;
    end
  end

  // enables sit in flops so a stray input cannot flip them mid-second
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ssf_en_reg <= 1'b0;
      rdi_en_reg <= 1'b0;
      odi_en_reg <= 1'b0;
      ais_en_reg <= 1'b0;
    end else if (i_config_load) begin
      ssf_en_reg <= i_server_fail_report_enable;
      rdi_en_reg <= i_far_defect_report_enable;
      odi_en_reg <= i_far_outgoing_report_enable;
      ais_en_reg <= i_upstream_alarm_report_enable;
    end
  end

  // ------------------------------------------------------------
  // consequent actions and fault causes
  // ------------------------------------------------------------
  logic ssf;
  logic conn_def;
  assign ssf = i_server_fail_input;
  assign conn_def = unequipped_reg | i_trace_mismatch_defect | loss_reg;
  assign o_upstream_alarm_defect = upstream_alarm_reg;
  assign o_unequipped_defect = unequipped_reg;
  assign o_tandem_loss_defect = loss_reg;
  assign o_alarm_fill_request = conn_def;
  assign o_trail_fail_action = ssf | conn_def;
  assign o_remote_defect_action = ssf | conn_def;
  assign o_outgoing_defect_action = ssf | conn_def | upstream_alarm_reg;
  assign o_outgoing_fail_action = ssf | conn_def | upstream_alarm_reg;
  assign o_trail_degrade_action = i_degrade_defect;
  assign o_remote_error_action = (i_near_block_error != 4'h0);
  assign o_outgoing_error_action = i_outgoing_near_block_error;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_fault_unequipped <= 1'b0;
      o_fault_loss <= 1'b0;
      o_fault_mismatch <= 1'b0;
      o_fault_degrade <= 1'b0;
      o_fault_server <= 1'b0;
      o_fault_far_defect <= 1'b0;
      o_fault_far_outgoing <= 1'b0;
      o_fault_upstream_alarm <= 1'b0;
    end else begin
      o_fault_unequipped <= i_monitored_state & unequipped_reg;
      o_fault_loss <= i_monitored_state & ~unequipped_reg & loss_reg;
      o_fault_mismatch <= i_monitored_state & ~unequipped_reg & ~loss_reg
                          & i_trace_mismatch_defect;
      o_fault_degrade <= i_monitored_state & ~i_trace_mismatch_defect & ~loss_reg
                         & i_degrade_defect;
      o_fault_server <= i_monitored_state & ssf & ssf_en_reg;
      o_fault_far_defect <= i_monitored_state & ~conn_def & i_far_defect_indication
                            & rdi_en_reg;
      o_fault_far_outgoing <= i_monitored_state & ~conn_def & i_far_outgoing_defect
                              & odi_en_reg;
      o_fault_upstream_alarm <= i_monitored_state & upstream_alarm_reg & ~ssf & ~loss_reg
                                & ~i_trace_mismatch_defect & ais_en_reg;
    end
  end

  // ------------------------------------------------------------
  // per-second performance
  // ------------------------------------------------------------
  logic nds_reg;
  logic fds_reg;
  logic onds_reg;
  logic ofds_reg;
  logic [CNT_W-1:0] nbc_reg;
  logic [CNT_W-1:0] fbc_reg;
  logic [CNT_W-1:0] onbc_reg;
  logic [CNT_W-1:0] ofbc_reg;

  // report on the second tick, then restart accumulation
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      nds_reg <= 1'b0;
      fds_reg <= 1'b0;
      onds_reg <= 1'b0;
      ofds_reg <= 1'b0;
      nbc_reg <= '0;
      fbc_reg <= '0;
      onbc_reg <= '0;
      ofbc_reg <= '0;
      o_near_defect_seconds <= 1'b0;
      o_far_defect_seconds <= 1'b0;
      o_outgoing_near_seconds <= 1'b0;
      o_outgoing_far_seconds <= 1'b0;
      o_near_block_count <= '0;
      o_far_block_count <= '0;
      o_outgoing_near_count <= '0;
      o_outgoing_far_count <= '0;
    end else if (i_one_second) begin
      o_near_defect_seconds <= nds_reg | o_trail_fail_action | i_equipment_defect;
      o_outgoing_near_seconds <= onds_reg | o_outgoing_defect_action
                                 | i_equipment_defect;
      o_far_defect_seconds <= fds_reg | i_far_defect_indication;
      o_outgoing_far_seconds <= ofds_reg | i_far_outgoing_defect;
      o_near_block_count <= nbc_reg;
      o_far_block_count <= fbc_reg;
      o_outgoing_near_count <= onbc_reg;
      o_outgoing_far_count <= ofbc_reg;
      nds_reg <= 1'b0;
      fds_reg <= 1'b0;
      onds_reg <= 1'b0;
      ofds_reg <= 1'b0;
      nbc_reg <= '0;
      fbc_reg <= '0;
      onbc_reg <= '0;
      ofbc_reg <= '0;
    end else begin
      nds_reg <= nds_reg | o_trail_fail_action | i_equipment_defect;
      onds_reg <= onds_reg | o_outgoing_defect_action | i_equipment_defect;
      fds_reg <= fds_reg | i_far_defect_indication;
      ofds_reg <= ofds_reg | i_far_outgoing_defect;
      if (i_frame_start) begin
        nbc_reg <= nbc_reg + CNT_W'(i_near_block_error);
        fbc_reg <= fbc_reg + CNT_W'(i_far_block_error);
        onbc_reg <= onbc_reg + CNT_W'(i_outgoing_near_block_error);
        ofbc_reg <= ofbc_reg + CNT_W'(i_outgoing_far_block_error);
      end
    end
  end

  // ------------------------------------------------------------
  // termination sink data path with all-ones fill
  // ------------------------------------------------------------
  logic [8:0] fifo_out;
  // fill applied at fifo output: takes effect next cycle, well under the bound
  tcm_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_byte_valid),
    .o_in_ready(o_in_ready),
    .i_in_data({i_frame_start, i_data}),
    .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready),
    .o_out_data(fifo_out)
  );

  logic fill_reg;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      fill_reg <= 1'b0;
    end else begin
      fill_reg <= o_alarm_fill_request;
    end
  end
  assign o_out_data = fill_reg ? FILL_BYTE : fifo_out[7:0];
  assign o_out_frame_start = fifo_out[8];

  // ------------------------------------------------------------
  // adaptation source holdover
  // ------------------------------------------------------------
  logic [1:0] tref_sync_reg;
  logic tref_prev_reg;
  logic tref_tick;
  logic [15:0] hold_pos_reg;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tref_sync_reg <= 2'h0;
      tref_prev_reg <= 1'b0;
    end else begin
      tref_sync_reg <= {tref_sync_reg[0], i_timing_reference_clock};
      tref_prev_reg <= tref_sync_reg[1];
    end
  end
  assign tref_tick = tref_sync_reg[1] & ~tref_prev_reg;

  // byte position counted on the reference timing, not the incoming signal
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      hold_pos_reg <= 16'h0;
    end else if (tref_tick) begin
      hold_pos_reg <= (hold_pos_reg == FRAME_BYTES - 16'h1) ? 16'h0 : hold_pos_reg + 16'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_holdover_data <= 8'h00;
      o_holdover_frame_start <= 1'b0;
    end else if (ssf) begin
      o_holdover_frame_start <= tref_tick && (hold_pos_reg == 16'h0);
      if (hold_pos_reg == 16'h0) begin
        o_holdover_data <= FA1_VALUE;
      end else if (hold_pos_reg == 16'h1) begin
        o_holdover_data <= FA2_VALUE;
      end else begin
        o_holdover_data <= FILL_BYTE;
      end
    end else begin
      o_holdover_data <= i_data;
      o_holdover_frame_start <= i_frame_start;
    end
  end
  assign o_adapted_fail_output = ssf;

  // ------------------------------------------------------------
  // adaptation sink
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_sink_data <= 8'h00;
    end else begin
      o_sink_data <= i_adapted_outgoing_fail ? FILL_BYTE : i_adapted_data;
    end
  end
  assign o_sink_server_fail = i_adapted_outgoing_fail;
  assign o_sink_fill_request = i_adapted_outgoing_fail;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  fill_prompt_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_alarm_fill_request |=> o_out_data == FILL_BYTE) else $error("fill not applied");
  fault_mask_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $past(unequipped_reg) |-> !o_fault_loss) else $error("loss fault not masked");
  alarm_persist_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(upstream_alarm_reg) |-> $past(alarm_code_seen)) else $error("alarm set wrongly");
  fail_action_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    upstream_alarm_reg |-> o_outgoing_fail_action && o_outgoing_defect_action)
    else $error("outgoing fail missing");
  trail_fail_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_server_fail_input || o_alarm_fill_request)
    |-> o_trail_fail_action && o_remote_defect_action) else $error("trail actions missing");
  sink_fail_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_adapted_outgoing_fail |=> o_sink_data == FILL_BYTE) else $error("sink fill missing");
  server_fault_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_fault_server |-> $past(ssf_en_reg)) else $error("server fault ungated");
  enable_default_a: assert property (@(posedge i_ref_clk)
    $past(i_sys_rst) && !i_sys_rst |-> !ssf_en_reg && !rdi_en_reg && !odi_en_reg && !ais_en_reg)
    else $error("enables not default off");
endmodule

// [tcm_path_source.sv]
// far-side path source: frame starts, overhead byte and byte stream
`timescale 1ns/100ps
module tcm_path_source (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_ohb_value,
  input wire logic i_send,
  input wire logic i_in_ready,
  output logic o_frame_start,
  output logic [7:0] o_tandem_overhead_byte,
  output logic o_byte_valid,
  output logic [7:0] o_data
);
  logic [1:0] phase;
  logic [7:0] next_byte;
  logic [7:0] ohb_s;
  logic rst_s, send_s, acc;
  initial begin
    phase = 2'h0;
    next_byte = 8'h00;
    o_frame_start = 1'b0;
    o_tandem_overhead_byte = 8'h00;
    o_byte_valid = 1'b0;
    o_data = 8'hff;
  end
  // ------------------------------------------------------------
  // frames every 4 cycles
  // ------------------------------------------------------------
  // idle lines show the inverse, so a stale value never passes as fresh
  always @(posedge i_ref_clk) begin
    rst_s = i_sys_rst;
    send_s = i_send;
    ohb_s = i_ohb_value;
    acc = o_byte_valid && i_in_ready;
    #1;
    phase = rst_s ? 2'h0 : phase + 2'h1;
    o_frame_start = !rst_s && phase == 2'h3;
    o_tandem_overhead_byte = o_frame_start ? ohb_s : ~o_tandem_overhead_byte;
    if (rst_s) begin
      next_byte = 8'h00;
    end else if (acc) begin
      next_byte = next_byte + 8'h01;
    end
    // a byte once offered stays offered until taken
    o_byte_valid = !rst_s && (send_s || (o_byte_valid && !acc));
    o_data = o_byte_valid ? next_byte : ~next_byte;
  end
endmodule

// [tb_tandem_connection_monitor.sv]
// self-checking testbench for the tandem connection monitor
`timescale 1ns/100ps
module tb_tandem_connection_monitor;
  import tcm_pkg::*;
  logic clk, rst, send, out_ready, fs, bv, in_ready, out_valid, tref, cfg, sec, outgoing_fail_action;
  logic ssf, mfl, tim, deg, rdi, odi, eq, mon, en_ssf, en_rdi, en_odi, en_ais, onbe, ofbe;
  logic d_ais, d_uneq, d_ltc, fill, tsf, tsd, rda, oda, osf, s_nds, s_fds, s_onds, s_ofds;
  logic f_uneq, f_ltc, f_tim, f_deg, f_ssf, f_rdi, f_odi, f_ais, a_fail, s_fail, s_fill;
  logic [7:0] ohb_val, ohb, data, out_data, hold, sdata, adata;
  logic [3:0] nbe, fbe;
  logic rea, oea, ofs, hfs;
  logic [CNT_W-1:0] c_n, c_f, c_on, c_of;
  int miscompares, cmp_count, cycles;

  tcm_path_source tcm_path_source_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_ohb_value(ohb_val),
    .i_send(send), .i_in_ready(in_ready), .o_frame_start(fs), .o_tandem_overhead_byte(ohb),
    .o_byte_valid(bv), .o_data(data));
  tandem_connection_monitor tandem_connection_monitor_inst (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_frame_start(fs), .i_byte_valid(bv), .i_data(data), .i_tandem_overhead_byte(ohb),
    .i_server_fail_input(ssf), .i_multiframe_lost_state(mfl), .i_trace_mismatch_defect(tim),
    .i_degrade_defect(deg), .i_far_defect_indication(rdi), .i_far_outgoing_defect(odi),
    .i_equipment_defect(eq), .i_near_block_error(nbe), .i_outgoing_near_block_error(onbe),
    .i_far_block_error(fbe), .i_outgoing_far_block_error(ofbe), .i_monitored_state(mon),
    .i_server_fail_report_enable(en_ssf), .i_far_defect_report_enable(en_rdi),
    .i_far_outgoing_report_enable(en_odi), .i_upstream_alarm_report_enable(en_ais),
    .i_config_load(cfg), .i_one_second(sec), .i_timing_reference_clock(tref),
    .i_adapted_outgoing_fail(outgoing_fail_action), .i_adapted_data(adata), .i_out_ready(out_ready),
    .o_in_ready(in_ready), .o_out_valid(out_valid), .o_out_data(out_data),
    .o_out_frame_start(ofs), .o_upstream_alarm_defect(d_ais), .o_unequipped_defect(d_uneq),
    .o_tandem_loss_defect(d_ltc), .o_alarm_fill_request(fill), .o_trail_fail_action(tsf),
    .o_trail_degrade_action(tsd), .o_remote_defect_action(rda), .o_remote_error_action(rea),
    .o_outgoing_defect_action(oda), .o_outgoing_error_action(oea), .o_outgoing_fail_action(osf),
    .o_fault_unequipped(f_uneq), .o_fault_loss(f_ltc), .o_fault_mismatch(f_tim),
    .o_fault_degrade(f_deg), .o_fault_server(f_ssf), .o_fault_far_defect(f_rdi),
    .o_fault_far_outgoing(f_odi), .o_fault_upstream_alarm(f_ais),
    .o_near_defect_seconds(s_nds), .o_far_defect_seconds(s_fds),
    .o_outgoing_near_seconds(s_onds), .o_outgoing_far_seconds(s_ofds),
    .o_near_block_count(c_n), .o_far_block_count(c_f), .o_outgoing_near_count(c_on),
    .o_outgoing_far_count(c_of), .o_holdover_data(hold), .o_holdover_frame_start(hfs),
    .o_adapted_fail_output(a_fail), .o_sink_data(sdata), .o_sink_server_fail(s_fail),
    .o_sink_fill_request(s_fill));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge clk iff fs === 1'b1);
    #1;
  endtask
  // change the byte just after a frame so every later frame carries it
  task automatic set_ohb(input logic [7:0] v);
    frames(1);
    ohb_val = v;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_fifo();
    int n;
    send = 1'b1;
    cyc(20);
    chk({in_ready, data}, 9'h008); // stall: exactly eight words stored
    send = 1'b0;
    out_ready = 1'b1;
    for (int k = 0; k < 9; k++) begin
      n = 0;
      while (out_valid !== 1'b1 && n < 20) begin
        cyc(1);
        n++;
      end
      // words taken on the frame-start edges carry the flag
      chk({ofs, out_data}, {(k == 2 || k == 6), 8'(k)});
      cyc(1);
    end
    chk(out_valid, 0);
  endtask
  task automatic t_alarm();
    set_ohb(8'he0);
    frames(4);
    chk(d_ais, 0);
    frames(1);
    chk({d_ais, oda, osf, fill, tsf, rda}, 6'h38);
    mon = 1'b1;
    en_ais = 1'b1;
    cyc(2);
    chk(f_ais, 0);
    pulse(cfg);
    cyc(2);
    chk(f_ais, 1);
    tim = 1'b1;
    cyc(2);
    chk({f_ais, f_tim, fill}, 3'h3);
    tim = 1'b0;
    ssf = 1'b1;
    cyc(2);
    chk({f_ais, f_ssf, tsf, rda, a_fail}, 5'h07);
    ssf = 1'b0;
    mfl = 1'b1;
    cyc(3);
    chk({f_ais, d_ltc, fill}, 3'h3);
    mfl = 1'b0;
    set_ohb(8'hf0);
    frames(4);
    ohb_val = 8'he0;
    frames(1);
    for (int k = 0; k < 16; k++) begin
      if (k != 14) begin
        ohb_val = {k[3:0], 4'h1};
        frames(1);
        if (k == 3) chk(d_ais, 1);
        if (k == 4) chk(d_ais, 0);
      end
    end
    chk({d_ais, osf}, 0);
  endtask
  task automatic t_uneq();
    set_ohb(8'h00);
    frames(4);
    chk(d_uneq, 0);
    frames(1);
    chk({d_uneq, fill, tsf, rda, osf, oda}, 6'h3f);
    mfl = 1'b1;
    tim = 1'b1;
    cyc(3);
    chk({d_ltc, f_uneq, f_ltc, f_tim}, 4'hc);
    send = 1'b1;
    cyc(12);
    chk({out_valid, out_data}, {1'b1, FILL_BYTE});
    send = 1'b0;
    set_ohb(8'h10);
    frames(5);
    chk(d_uneq, 0);
    cyc(2);
    chk({f_uneq, f_ltc, f_tim}, 3'h2);
    mfl = 1'b0;
    cyc(3);
    chk({d_ltc, f_tim}, 2'h1);
    deg = 1'b1;
    cyc(2);
    chk({tsd, f_deg}, 2'h2);
    tim = 1'b0;
    cyc(2);
    chk({fill, f_deg}, 2'h1);
    deg = 1'b0;
    send = 1'b1;
    cyc(6);
    chk(out_data === FILL_BYTE, 0);
    send = 1'b0;
  endtask
  task automatic t_enables();
    en_ssf = 1'b1;
    en_rdi = 1'b1;
    en_odi = 1'b1;
    pulse(cfg);
    ssf = 1'b1;
    rdi = 1'b1;
    odi = 1'b1;
    cyc(2);
    chk({f_ssf, f_rdi, f_odi}, 3'h7);
    ssf = 1'b0;
    tim = 1'b1;
    cyc(2);
    chk({f_ssf, f_rdi, f_odi}, 3'h0);
    tim = 1'b0;
    mon = 1'b0;
    ssf = 1'b1;
    cyc(2);
    chk({f_ssf, f_rdi}, 2'h0);
    {mon, ssf, rdi, odi} = 4'h8;
  endtask
  task automatic t_seconds();
    frames(1);
    pulse(sec);
    {nbe, fbe, onbe, ofbe, eq, rdi, odi} = {4'h3, 4'h2, 5'h1f};
    cyc(1);
    chk({rea, oea}, 2'h3);
    frames(3);
    {nbe, fbe, onbe, ofbe, eq, rdi, odi} = '0;
    pulse(sec);
    chk({c_n, c_f}, {24'd9, 24'd6});
    chk({c_on, c_of}, {24'd3, 24'd3});
    chk({s_nds, s_fds, s_onds, s_ofds}, 4'hf);
    cyc(3);
    pulse(sec);
    chk({s_nds, s_fds, s_onds, s_ofds, rea, oea, c_n[3:0]}, 0);
  endtask
  task automatic t_sink_hold();
    int n, m, bad;
    adata = 8'h5a;
    cyc(2);
    chk({sdata, s_fail, s_fill}, {8'h5a, 2'h0});
    outgoing_fail_action = 1'b1;
    cyc(2);
    chk({sdata, s_fail, s_fill}, {FILL_BYTE, 2'h3});
    outgoing_fail_action = 1'b0;
    ssf = 1'b1;
    cyc(4);
    chk({sdata, s_fail, s_fill}, {8'h5a, 2'h0});
    n = 0;
    m = 0;
    bad = 0;
    for (int k = 0; k < 20000; k++) begin
      if (hfs === 1'b1) n++;
      if (hfs === 1'b1 && hold !== FA1_VALUE) bad++;
      if (hold === FA2_VALUE) m++;
      if (hold !== FILL_BYTE && hold !== FA1_VALUE && hold !== FA2_VALUE) bad++;
      cyc(1);
    end
    chk(24'(bad), 0);
    chk(n > 0, 1);
    chk(m > 0, 1);
    ssf = 1'b0;
  endtask

  // ------------------------------------------------------------
  // clocks, timeout and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // reference timing runs free and unrelated to the main clock
  initial begin
    tref = 1'b0;
    forever #37 tref = ~tref;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    {send, out_ready, cfg, sec, ssf, mfl, tim, deg, rdi, odi, eq, mon} = '0;
    {en_ssf, en_rdi, en_odi, en_ais, onbe, ofbe, outgoing_fail_action, nbe, fbe} = '0;
    ohb_val = 8'h10;
    adata = 8'h00;
    rst = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    cyc(10);
    rst = 1'b0;
    chk({d_ais, d_uneq, d_ltc, f_uneq, f_ltc, f_tim, f_deg, f_ais}, 0);
    t_fifo();
    t_alarm();
    t_uneq();
    t_enables();
    t_seconds();
    t_sink_hold();
    finish_test();
  end
endmodule
